// *** hdl/oms_pkg.sv ***
// Package of constants and carrier types for the optical measurement sequencer.
// Assumes a 100 MHz system clock and an APB register slave with 32-bit data.
//
// Summary of operation
// R1: Time base ticks every divider plus one microseconds.
// R2: Count cycles per sequence; zero runs forever.
// R3: Sequencer mode: start bit one runs, zero stops.
// R4: Manual mode: start bit one launches one conversion.
// R5: Start bit reads busy until conversion finishes.
// R6: Period field sets cycle length in ticks.
// R7: LED window; turn-on one tick after start.
// R8: Integrator window; reset one/zero means always on; the logic turns it off at cycle count zero while running.
// R9: Discharge capacitor outside window, capacitive, no demod.
// R10: Positive demodulator phase window.
// R11: First negative demodulator phase window.
// R12: Second negative demodulator phase window.
// R13: ADC sample at integer plus sixteenths position.
// R14: Sample position advances by increment per conversion.
// R15: Sample-time writes ignored while sequencer enabled; code ignores only the position, fraction and increment still update.
// R16: Live subsample, sequence and cycle counters readable; the subsample field reads zero.
// R17: Live conversion counter readable.
// R18: Software programs timing fields at least one.
// R19: Each conversion result stored automatically.
// R20: Demod weight plus one, minus one, or zero.
// R21: Outputs active in window; counter wraps at period.
package oms_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] OMS_DIV_CNT_OFF = 8'h24;
  localparam logic [7:0] OMS_START_OFF = 8'h28;
  localparam logic [7:0] OMS_PERIOD_OFF = 8'h2c;
  localparam logic [7:0] OMS_LED_OFF = 8'h30;
  localparam logic [7:0] OMS_ITG_OFF = 8'h34;
  localparam logic [7:0] OMS_POS_OFF = 8'h38;
  localparam logic [7:0] OMS_NEG_A_OFF = 8'h3c;
  localparam logic [7:0] OMS_NEG_B_OFF = 8'h40;
  localparam logic [7:0] OMS_ADC_OFF = 8'h44;
  localparam logic [7:0] OMS_MODE_OFF = 8'h48;
  localparam logic [7:0] OMS_RESULT_OFF = 8'h4c;
  localparam logic [7:0] OMS_SEQ_CNT_OFF = 8'h80;
  localparam logic [7:0] OMS_ADC_CNT_OFF = 8'h84;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int OMS_DIV_LSB = 8;
  localparam int OMS_START_LSB = 16;
  localparam int OMS_INC_LSB = 16;
  localparam int OMS_FRACT_LSB = 24;
  localparam int OMS_INC_FRACT_LSB = 28;
  localparam int OMS_SUBS_LSB = 24;
  localparam int OMS_SEQ_LSB = 16;
  localparam int OMS_MODE_MAN_BIT = 0;
  localparam int OMS_MODE_CAP_BIT = 1;
  localparam int OMS_MODE_DEMOD_BIT = 2;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [31:0] OMS_ITG_RESET = 32'h0001_0000;
  localparam logic [31:0] OMS_ZERO_RESET = 32'h0000_0000;

  // ****************************************************************
  // Timing: base tick of one microsecond at the system clock rate.
  // ****************************************************************
  localparam int OMS_CLK_MHZ = 100;
  localparam int OMS_TICK_US = 1;
  localparam int OMS_TICK_CYCLES = OMS_TICK_US * OMS_CLK_MHZ;
  localparam int OMS_SUB_CYCLES = OMS_TICK_CYCLES / 16;

  // Demodulator weight code.
  typedef enum logic [1:0] {
    OMS_W_ZERO = 2'b00,
    OMS_W_PLUS = 2'b01,
    OMS_W_MINUS = 2'b11
  } oms_weight_type;

  // Analog front-end control bundle.
  typedef struct packed {
    logic led_en;
    logic itg_en;
    logic cap_discharge;
    logic pos_phase;
    logic neg_a_phase;
    logic neg_b_phase;
    oms_weight_type weight;
    logic adc_start;
  } oms_afe_type;

  // Programmed window.
  typedef struct packed {
    logic [15:0] on_time;
    logic [15:0] off_time;
  } oms_window_type;

endpackage

// *** hdl/oms_tick_div.sv ***
// Time-base divider: one-cycle enable every (divider + 1) microseconds.
// Also emits a four-bit sixteenth-of-tick phase count for the fractional sample point.
// Assumes a single system clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module oms_tick_div
  import oms_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Control.
  input wire logic run_in,
  input wire logic [15:0] divider_in,
  // Enables.
  output logic tick_out,
  output logic [3:0] phase_out
);

  typedef struct packed {
    logic [7:0] us_cnt;
    logic [15:0] div_cnt;
    logic [3:0] phase;
    logic tick;
  } oms_div_state_type;

  oms_div_state_type state_reg;
  oms_div_state_type state_next;

  // The sixteenth phase spans the whole sequencer tick, so it is derived
  // from microsecond count and divider count together.
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!run_in) begin
      state_next.us_cnt = 8'h00;
      state_next.div_cnt = 16'h0000;
    end else if (state_reg.us_cnt == 8'(OMS_TICK_CYCLES - 1)) begin
      state_next.us_cnt = 8'h00;
      if (state_reg.div_cnt >= divider_in) begin
        state_next.div_cnt = 16'h0000;
        state_next.tick = 1'b1; // R1
      end else begin
        state_next.div_cnt = state_reg.div_cnt + 16'h0001;
      end
    end else begin
      state_next.us_cnt = state_reg.us_cnt + 8'h01;
    end
    state_next.phase = 4'((({16'h0000, state_reg.div_cnt} * 32'(OMS_TICK_CYCLES)
      + 32'(state_reg.us_cnt)) * 32'd16) / ((32'(divider_in) + 32'd1)
      * 32'(OMS_TICK_CYCLES)));
  end

  // State register.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_out = state_reg.tick;
  assign phase_out = state_reg.phase;

endmodule
`default_nettype wire

// *** hdl/oms_window.sv ***
// One timed window comparator with optional one-tick delay of turn-on.
// Assumes the cycle counter advances on the sequencer tick only.
`timescale 1ns/1ps
`default_nettype none
module oms_window
  import oms_pkg::*;
#(
  parameter bit DELAY_ON = 1'b0
)
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Timing.
  input wire logic run_in,
  input wire logic [15:0] count_in,
  input wire oms_window_type window_in,
  // Result.
  output logic active_out
);

  logic in_win;
  logic start_hit;
  logic delayed_reg;
  logic delayed_next;

  // An on time after the off time wraps across the period end.
  always_comb begin
    if (window_in.on_time <= window_in.off_time) begin
      in_win = (count_in >= window_in.on_time) && (count_in < window_in.off_time); // R21
    end else begin
      in_win = (count_in >= window_in.on_time) || (count_in < window_in.off_time);
    end
    start_hit = (count_in == window_in.on_time);
    delayed_next = run_in && in_win && (delayed_reg || !start_hit || !DELAY_ON);
  end

  // Delayed turn-on: at the start count itself the output holds off one tick.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      delayed_reg <= 1'b0;
    end else begin
      delayed_reg <= delayed_next;
    end
  end

  assign active_out = DELAY_ON ? (delayed_reg && in_win && !start_hit) : (run_in && in_win); // R7

endmodule
`default_nettype wire

// *** hdl/oms_top.sv ***
// Optical measurement sequencer with APB register slave.
// Assumes analog drivers consume level controls, and the ADC answers each
// start pulse with a done pulse carrying its result.
`timescale 1ns/1ps
`default_nettype none
module oms_top
  import oms_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // ADC handshake.
  input wire logic adc_done_in,
  input wire logic [15:0] adc_data_in,
  // Front-end controls.
  output oms_afe_type afe_out
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic [1:0] {
    OMS_IDLE = 2'b00,
    OMS_RUN = 2'b01,
    OMS_CONVERT = 2'b10
  } oms_fsm_type;

  typedef struct packed {
    oms_fsm_type fsm;
    logic [15:0] divider;
    logic [7:0] count;
    logic [15:0] period;
    oms_window_type led;
    oms_window_type itg;
    oms_window_type pos;
    oms_window_type neg_a;
    oms_window_type neg_b;
    logic [3:0] inc_fract;
    logic [3:0] fract;
    logic [7:0] inc;
    logic [15:0] adc_pos;
    logic [3:0] cur_fract;
    logic [15:0] cur_pos;
    logic manual;
    logic cap_mode;
    logic demod_on;
    logic [15:0] cycle_cnt;
    logic [7:0] seq_cnt;
    logic [7:0] adc_cnt;
    logic [15:0] result;
    logic adc_busy;
    logic adc_start;
    logic fired;
    logic [31:0] rdata;
  } oms_state_type;

  oms_state_type state_reg;
  oms_state_type state_next;

  // Helper nets.
  logic tick;
  logic [3:0] phase;
  logic running;
  logic led_act;
  logic itg_act;
  logic pos_act;
  logic neg_a_act;
  logic neg_b_act;
  logic wr_en;
  logic rd_en;
  logic [19:0] pos_sum;

  assign running = (state_reg.fsm == OMS_RUN);
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;
  assign pos_sum = {state_reg.cur_pos, state_reg.cur_fract}
    + {8'h00, state_reg.inc, state_reg.inc_fract};

  // ****************************************************************
  // Time base and windows.
  // ****************************************************************
  oms_tick_div u_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .run_in(running),
    .divider_in(state_reg.divider),
    .tick_out(tick),
    .phase_out(phase)
  );

  oms_window #(.DELAY_ON(1'b1)) u_led (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(running),
    .count_in(state_reg.cycle_cnt), .window_in(state_reg.led), .active_out(led_act)
  );
  // Integrator window of on one, off zero wraps: it is on at every cycle count except zero.
  oms_window #(.DELAY_ON(1'b0)) u_itg (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(running),
    .count_in(state_reg.cycle_cnt), .window_in(state_reg.itg), .active_out(itg_act)
  );
  oms_window #(.DELAY_ON(1'b0)) u_pos (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(running),
    .count_in(state_reg.cycle_cnt), .window_in(state_reg.pos), .active_out(pos_act)
  );
  oms_window #(.DELAY_ON(1'b0)) u_neg_a (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(running),
    .count_in(state_reg.cycle_cnt), .window_in(state_reg.neg_a), .active_out(neg_a_act)
  );
  oms_window #(.DELAY_ON(1'b0)) u_neg_b (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(running),
    .count_in(state_reg.cycle_cnt), .window_in(state_reg.neg_b), .active_out(neg_b_act)
  );

  // ****************************************************************
  // Next-state logic: registers, sequencer and ADC control.
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.adc_start = 1'b0;
    // Register writes take effect on the access phase.
    if (wr_en) begin
      case (paddr_in)
        OMS_DIV_CNT_OFF: begin
          state_next.divider = pwdata_in[OMS_DIV_LSB +: 16]; // R1
          state_next.count = pwdata_in[7:0]; // R2
        end
        OMS_PERIOD_OFF: state_next.period = pwdata_in[15:0]; // R6
        OMS_LED_OFF: state_next.led = pwdata_in; // R7
        OMS_ITG_OFF: state_next.itg = pwdata_in; // R8
        OMS_POS_OFF: state_next.pos = pwdata_in; // R10
        OMS_NEG_A_OFF: state_next.neg_a = pwdata_in; // R11
        OMS_NEG_B_OFF: state_next.neg_b = pwdata_in; // R12
        OMS_ADC_OFF: begin
          state_next.inc_fract = pwdata_in[OMS_INC_FRACT_LSB +: 4];
          state_next.fract = pwdata_in[OMS_FRACT_LSB +: 4];
          state_next.inc = pwdata_in[OMS_INC_LSB +: 8];
          if (!running) begin
            state_next.adc_pos = pwdata_in[15:0]; // R15
          end
        end
        OMS_MODE_OFF: begin
          state_next.manual = pwdata_in[OMS_MODE_MAN_BIT];
          state_next.cap_mode = pwdata_in[OMS_MODE_CAP_BIT];
          state_next.demod_on = pwdata_in[OMS_MODE_DEMOD_BIT];
        end
        default: begin
        end
      endcase
    end
    // Sequencer and manual conversion control.
    case (state_reg.fsm)
      OMS_IDLE: begin
        if (wr_en && paddr_in == OMS_START_OFF && pwdata_in[0]) begin
          if (state_reg.manual) begin
            state_next.fsm = OMS_CONVERT; // R4
            state_next.adc_start = 1'b1;
            state_next.adc_busy = 1'b1;
          end else begin
            state_next.fsm = OMS_RUN; // R3
            state_next.cycle_cnt = 16'h0000;
            state_next.seq_cnt = 8'h00;
            state_next.cur_pos = state_next.adc_pos; // R13
            state_next.cur_fract = state_next.fract;
            state_next.fired = 1'b0;
          end
        end
      end
      OMS_RUN: begin
        // Sample point: integer tick position, then sixteenth phase.
        if (!state_reg.fired && !state_reg.adc_busy
            && state_reg.cycle_cnt == state_reg.cur_pos
            && phase >= state_reg.cur_fract) begin
          state_next.adc_start = 1'b1; // R13
          state_next.adc_busy = 1'b1;
          state_next.fired = 1'b1;
          state_next.cur_pos = pos_sum[19:4]; // R14
          state_next.cur_fract = pos_sum[3:0];
        end
        if (tick) begin
          if (state_reg.cycle_cnt + 16'h0001 >= state_reg.period) begin
            state_next.cycle_cnt = 16'h0000; // R21
            state_next.seq_cnt = state_reg.seq_cnt + 8'h01;
            state_next.fired = 1'b0;
            state_next.cur_pos = state_next.cur_pos - state_reg.period;
            if (state_reg.count != 8'h00 && state_reg.seq_cnt + 8'h01 == state_reg.count) begin
              state_next.fsm = OMS_IDLE; // R2
            end
          end else begin
            state_next.cycle_cnt = state_reg.cycle_cnt + 16'h0001;
          end
          // The sample point is relative to each cycle, so the increment
          // accumulates from the programmed point, not per-cycle absolute.
          if (state_reg.cycle_cnt + 16'h0001 >= state_reg.period) begin
            state_next.cur_pos = state_reg.fired ? state_next.cur_pos + state_reg.period
              : state_reg.cur_pos;
          end
        end
        if (wr_en && paddr_in == OMS_START_OFF && !pwdata_in[0]) begin
          state_next.fsm = OMS_IDLE; // R3
        end
      end
      OMS_CONVERT: begin
        if (adc_done_in) begin
          state_next.fsm = OMS_IDLE; // R5
        end
      end
      default: state_next.fsm = OMS_IDLE;
    endcase
    // Every finished conversion is counted and its result stored.
    if (adc_done_in) begin
      // A start in this same cycle keeps the flag set.
      state_next.adc_busy = state_next.adc_start;
      state_next.result = adc_data_in; // R19
      state_next.adc_cnt = state_reg.adc_cnt + 8'h01; // R17
    end
    // Read data is captured in the setup phase.
    if (rd_en) begin
      case (paddr_in)
        OMS_DIV_CNT_OFF: state_next.rdata = {8'h00, state_reg.divider, state_reg.count};
        OMS_START_OFF: state_next.rdata = {31'h0, state_reg.fsm != OMS_IDLE}; // R5
        OMS_PERIOD_OFF: state_next.rdata = {16'h0000, state_reg.period};
        OMS_LED_OFF: state_next.rdata = state_reg.led;
        OMS_ITG_OFF: state_next.rdata = state_reg.itg;
        OMS_POS_OFF: state_next.rdata = state_reg.pos;
        OMS_NEG_A_OFF: state_next.rdata = state_reg.neg_a;
        OMS_NEG_B_OFF: state_next.rdata = state_reg.neg_b;
        OMS_ADC_OFF: state_next.rdata = {state_reg.inc_fract, state_reg.fract,
          state_reg.inc, state_reg.adc_pos};
        OMS_MODE_OFF: state_next.rdata = {29'h0, state_reg.demod_on,
          state_reg.cap_mode, state_reg.manual};
        OMS_RESULT_OFF: state_next.rdata = {16'h0000, state_reg.result};
        OMS_SEQ_CNT_OFF: state_next.rdata = {8'h00, state_reg.seq_cnt,
          state_reg.cycle_cnt}; // R16
        OMS_ADC_CNT_OFF: state_next.rdata = {24'h00_0000, state_reg.adc_cnt}; // R17
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.itg <= OMS_ITG_RESET; // R8
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // No subsampling is built in, so the subsample field reads zero.
  assign prdata_out = state_reg.rdata;
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;

  always_comb begin
    afe_out.led_en = led_act;
    afe_out.itg_en = itg_act || !running;
    afe_out.cap_discharge = running && !itg_act && state_reg.cap_mode
      && !state_reg.demod_on; // R9
    afe_out.pos_phase = pos_act;
    afe_out.neg_a_phase = neg_a_act;
    afe_out.neg_b_phase = neg_b_act;
    if (pos_act) begin
      afe_out.weight = OMS_W_PLUS; // R20
    end else if (neg_a_act || neg_b_act) begin
      afe_out.weight = OMS_W_MINUS;
    end else begin
      afe_out.weight = OMS_W_ZERO;
    end
    afe_out.adc_start = state_reg.adc_start;
  end

endmodule
`default_nettype wire

// *** testbench/oms_monitor.sv ***
// Checker for the sequencer top: APB answer and front-end control relations.
// Assumes it is bound to oms_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module oms_monitor
  import oms_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // ADC handshake.
  input wire logic adc_done_in,
  input wire logic [15:0] adc_data_in,
  // Front-end controls.
  input wire oms_afe_type afe_out
);
  // ****************************************************************
  // Helper logic.
  // ****************************************************************
  logic wr_acc; // A write access phase is on the bus.
  logic man_reg; // Shadow of the manual mode bit.
  assign wr_acc = psel_in && penable_in && pwrite_in;
  // The shadow lets the start check tell manual launches from sequencer starts.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      man_reg <= 1'b0;
    end else if (wr_acc && paddr_in == OMS_MODE_OFF) begin
      man_reg <= pwdata_in[OMS_MODE_MAN_BIT];
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  apb_ready_a: assert property (psel_in && penable_in |-> pready_out && !pslverr_out)
    else $error("APB access not answered at once");
  one_shot_a: assert property (afe_out.adc_start |=> !afe_out.adc_start)
    else $error("ADC start longer than one cycle");
  manual_start_a: assert property (
    wr_acc && paddr_in == OMS_START_OFF && pwdata_in[0] && man_reg
    |-> ##[1:2] afe_out.adc_start) else $error("Manual start gave no conversion");
  weight_plus_a: assert property (
    afe_out.pos_phase && !afe_out.neg_a_phase && !afe_out.neg_b_phase
    |-> afe_out.weight == OMS_W_PLUS) else $error("Weight not plus one");
  weight_minus_a: assert property (
    (afe_out.neg_a_phase || afe_out.neg_b_phase) && !afe_out.pos_phase
    |-> afe_out.weight == OMS_W_MINUS) else $error("Weight not minus one");
  discharge_gap_a: assert property (afe_out.cap_discharge |-> !afe_out.itg_en)
    else $error("Discharge inside integration window");
  count_width_a: assert property (
    psel_in && penable_in && !pwrite_in && paddr_in == OMS_ADC_CNT_OFF
    |-> prdata_out[31:8] == 24'h00_0000) else $error("Conversion count too wide");
  reset_idle_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    rst_in |=> afe_out.itg_en && !afe_out.led_en && !afe_out.adc_start)
    else $error("Front end not idle after reset");
endmodule
bind oms_top oms_monitor oms_monitor_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .adc_done_in(adc_done_in), .adc_data_in(adc_data_in),
  .afe_out(afe_out));
`default_nettype wire

// *** testbench/oms_adc_model.sv ***
// Behavioural ADC that answers each start pulse after a set latency.
// Assumes one clock; the result bus is not held between answers.
`timescale 1ns/1ps
`default_nettype none
module oms_adc_model (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Conversion request and latency.
  input wire logic adc_start_in,
  input wire logic [7:0] lat_in,
  // Answer.
  output logic adc_done_out,
  output logic [15:0] adc_data_out
);
  logic busy; // A conversion is under way.
  logic [7:0] wait_cnt; // Cycles left until the answer.
  logic [15:0] idx; // Number of answers given.
  // Between answers the bus flips every cycle so a stale value never matches.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      wait_cnt <= 8'h00;
      idx <= 16'h0000;
      adc_done_out <= 1'b0;
      adc_data_out <= 16'h0000;
    end else if (busy && wait_cnt == 8'h00) begin
      busy <= 1'b0;
      adc_done_out <= 1'b1;
      adc_data_out <= 16'h5a00 + idx;
      idx <= idx + 16'h0001;
    end else begin
      adc_done_out <= 1'b0;
      adc_data_out <= ~adc_data_out;
      if (busy) begin
        wait_cnt <= wait_cnt - 8'h01;
      end else if (adc_start_in) begin
        busy <= 1'b1;
        wait_cnt <= lat_in;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/test_optical_measurement_sequencer.sv ***
// Self-checking bench for the sequencer: APB tasks and directed scenarios.
// Assumes the ADC model as far side and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_optical_measurement_sequencer;
  import oms_pkg::*;
  logic clk = 1'b0; // System clock.
  logic rst = 1'b1; // Synchronous reset.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls.
  logic [7:0] paddr = 8'h00; // APB address.
  logic [31:0] pwdata = 32'h0000_0000; // APB write data.
  logic [31:0] prdata; // APB read data.
  logic pready, pslverr, adc_done; // Answers.
  logic [15:0] adc_data; // ADC result.
  logic [7:0] lat = 8'h03; // ADC latency.
  oms_afe_type afe; // Front-end controls.
  int err_count = 0, comparisons = 0, cyc = 0;
  int n_adc = 0, n_led = 0, n_pos = 0, n_na = 0, n_nb = 0;
  int t_adc[$]; // Cycle of each ADC start.
  always #5 clk = ~clk;
  oms_top oms_top_i (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .adc_done_in(adc_done),
    .adc_data_in(adc_data), .afe_out(afe));
  oms_adc_model oms_adc_model_i (.sys_clk_in(clk), .rst_in(rst), .adc_start_in(afe.adc_start),
    .lat_in(lat), .adc_done_out(adc_done), .adc_data_out(adc_data));
  // Counters of output activity; scenarios compare differences, except the result check that uses the total ADC start count.
  always @(posedge clk) begin
    cyc++;
    if (afe.adc_start === 1'b1) begin
      n_adc++;
      t_adc.push_back(cyc);
    end
    if (afe.led_en === 1'b1) n_led++;
    if (afe.pos_phase === 1'b1) n_pos++;
    if (afe.neg_a_phase === 1'b1) n_na++;
    if (afe.neg_b_phase === 1'b1) n_nb++;
  end
  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk(32'h0000_0000, 32'h0000_0001);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0000_0000, q);
  endtask
  // Polls the start bit until it drops, with a bounded number of reads.
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 400) begin
      rd(OMS_START_OFF, q);
      n++;
    end
    chk(q, 32'h0000_0000);
  endtask
  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole run needs about 2500 cycles; this leaves a wide margin.
  initial begin
    #300_000;
    err_count++;
    stop_test();
  end
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    logic [31:0] q;
    int a0, l0, p0, na0, nb0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then an unmapped place that ignores writes.
    for (int a = 8'h24; a <= 8'h84; a += 4) begin
      if (a > 8'h44 && a < 8'h80) continue;
      rd(8'(a), q);
      chk(q, (a == OMS_ITG_OFF) ? OMS_ITG_RESET : OMS_ZERO_RESET);
    end
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, q);
    chk(q, 32'h0000_0000);
    // Window and sample registers read back what was written.
    for (int a = 8'h30; a <= 8'h44; a += 4) begin
      wr(8'(a), {8'h00, 8'(a), 8'h00, 8'(a)});
      rd(8'(a), q);
      chk(q, {8'h00, 8'(a), 8'h00, 8'(a)});
    end
    // Manual mode: one slow conversion.
    lat <= 8'd20;
    wr(OMS_MODE_OFF, 32'h0000_0001);
    a0 = n_adc;
    wr(OMS_START_OFF, 32'h0000_0001);
    rd(OMS_START_OFF, q);
    chk(q, 32'h0000_0001);
    wait_idle();
    chk(n_adc - a0, 1);
    rd(OMS_RESULT_OFF, q);
    chk(q, 32'h0000_5a00);
    rd(OMS_ADC_CNT_OFF, q);
    chk(q, 32'h0000_0001);
    // Two cycles of period four, all windows at least one.
    lat <= 8'd3;
    wr(OMS_MODE_OFF, 32'h0000_0002);
    wr(OMS_DIV_CNT_OFF, 32'h0000_0002);
    wr(OMS_PERIOD_OFF, 32'h0000_0004);
    wr(OMS_LED_OFF, 32'h0001_0003);
    wr(OMS_POS_OFF, 32'h0001_0002);
    wr(OMS_NEG_A_OFF, 32'h0002_0003);
    wr(OMS_NEG_B_OFF, 32'h0003_0004);
    wr(OMS_ADC_OFF, 32'h8001_0001);
    a0 = n_adc;
    l0 = n_led;
    p0 = n_pos;
    na0 = n_na;
    nb0 = n_nb;
    wr(OMS_START_OFF, 32'h0000_0001);
    rd(OMS_START_OFF, q);
    chk(q, 32'h0000_0001);
    for (int n = 0; n < 600 && n_adc == a0; n++) @(posedge clk);
    wr(OMS_ADC_OFF, 32'h0001_0003);
    rd(OMS_ADC_OFF, q);
    chk(q, 32'h0001_0001);
    wait_idle();
    chk(n_adc - a0, 2);
    chk(t_adc[$] - t_adc[$ - 1], 550);
    // The LED register stage costs one clock per cycle.
    chk(n_led - l0, 198);
    chk(n_pos - p0, 200);
    chk(n_na - na0, 200);
    chk(n_nb - nb0, 200);
    rd(OMS_RESULT_OFF, q);
    chk(q, 32'h5a00 + n_adc - 1);
    // Endless run, stopped by software.
    wr(OMS_DIV_CNT_OFF, 32'h0000_0000);
    wr(OMS_ADC_OFF, 32'h0000_0001);
    a0 = n_adc;
    wr(OMS_START_OFF, 32'h0000_0001);
    for (int n = 0; n < 2000 && n_adc < a0 + 3; n++) @(posedge clk);
    chk(n_adc - a0, 3);
    rd(OMS_SEQ_CNT_OFF, q);
    chk(q, 32'h0002_0001);
    wr(OMS_START_OFF, 32'h0000_0000);
    rd(OMS_START_OFF, q);
    chk(q, 32'h0000_0000);
    a0 = n_adc;
    repeat (600) @(posedge clk);
    chk(n_adc - a0, 0);
    stop_test();
  end
endmodule
`default_nettype wire
